//--- src/dual_gain_amp_regs.vh
// Notes on behaviour
// [R1] Independent gain per channel, -9 to 30 dB in 1 dB steps, at 5h/7h.
// [R2] Gain code zero gives the maximum gain of 30 dB.
// [R3] Gain code 27h gives -9 dB; each code step lowers gain by 1 dB.
// [R4] Both gain registers are read/write and reset to 14h, a 10 dB gain.
// [R5] Bias registers at 4h and 6h are read/write and reset to 20h.
// [R6] Reset loads defaults; soft reset at 2 and power-down at 3 read 00h.
// [R7] A serial host writes and reads every configuration register over the serial bus.
// [R8] Revision and product codes at 0 and 1 are read-only; writes are ignored.
`ifndef DUAL_GAIN_AMP_REGS_VH
`define DUAL_GAIN_AMP_REGS_VH

// Register addresses, seven bits wide
`define ADDR_W 7
`define ADDR_REVISION_CODE 7'h00
`define ADDR_PRODUCT_CODE 7'h01
`define ADDR_SOFT_RESET_CTRL 7'h02
`define ADDR_POWER_DOWN_CTRL 7'h03
`define ADDR_FIRST_CHANNEL_BIAS 7'h04
`define ADDR_FIRST_CHANNEL_GAIN 7'h05
`define ADDR_SECOND_CHANNEL_BIAS 7'h06
`define ADDR_SECOND_CHANNEL_GAIN 7'h07

// Reset values
`define RST_SOFT_RESET_CTRL 8'h00
`define RST_POWER_DOWN_CTRL 8'h00
`define RST_CHANNEL_BIAS 8'h20
`define RST_CHANNEL_GAIN 8'h14
`define RST_GAIN_DB 8'h0A

// Gain law: code 0 is the top of the range, one decibel per code step
`define GAIN_CODE_MAX 8'h27
`define GAIN_DB_TOP 8'sh1E
`define GAIN_DB_BOTTOM 8'shF7

// Serial frame: read flag, seven address bits, eight data bits
`define FRAME_BITS 16
`define FRAME_RW_BIT 15
`define FRAME_ADDR_MSB 14
`define FRAME_ADDR_LSB 8
`define FRAME_DATA_MSB 7
`define FRAME_HEAD_BITS 8
`define BIT_CNT_W 5

`endif

//--- src/dual_gain_amp_register_bank.v
`timescale 1ns/1ps
`include "dual_gain_amp_regs.vh"

module dual_gain_amp_register_bank
#(
   parameter [7:0] REVISION_VALUE = 8'h5A, // Arbitrary value
   parameter [7:0] PRODUCT_VALUE = 8'hA5, // Arbitrary value
   parameter CHANNELS = 2
)
(
   // Clock, reset, enable
   input wire ref_clk,
   input wire resetn,
   input wire clk_en,
   // Serial programming port
   input wire sclk,
   input wire sen_n,
   input wire sdi,
   output reg sdo,
   output wire sdo_oe,
   // Configuration towards the amplifier
   output wire [7:0] soft_reset_code,
   output wire [7:0] power_down_code,
   output wire [7:0] first_bias_code,
   output wire [7:0] first_gain_code,
   output wire [7:0] second_bias_code,
   output wire [7:0] second_gain_code,
   // Gain in decibels, two's complement, per channel
   output wire [7:0] first_gain_db,
   output wire [7:0] second_gain_db,
   // Frame status
   output reg write_done
);

   // Code to decibels; codes past the bottom of the range hold at -9 dB
   function [7:0] code_to_db;
      input [7:0] code;
      begin
         if (code > `GAIN_CODE_MAX)
         begin
            code_to_db = `GAIN_DB_BOTTOM; // [R3]
         end
         else
         begin
            code_to_db = `GAIN_DB_TOP - code; // [R1] [R2] [R3]
         end
      end
   endfunction

   // Write strobe for one address; shared by every writable register
   function wr_hit;
      input strobe;
      input [`ADDR_W-1:0] addr;
      input [`ADDR_W-1:0] target;
      begin
         wr_hit = strobe && (addr == target);
      end
   endfunction

   // Register file contents; index 0 is the first channel
   reg [7:0] soft_reset_r;
   reg [7:0] power_down_r;
   reg [7:0] bias_r [0:CHANNELS-1];
   reg [7:0] gain_r [0:CHANNELS-1];
   reg [7:0] gain_db_r [0:CHANNELS-1];

   // Serial engine state
   reg sclk_d_r;
   reg [`BIT_CNT_W-1:0] bit_cnt_r;
   reg [`FRAME_BITS-2:0] shift_r;
   reg is_read_r;
   reg [7:0] rd_shift_r;
   reg frame_on_r;

   wire sclk_rise;
   wire [`FRAME_BITS-1:0] frame_word;
   wire [`ADDR_W-1:0] head_addr;
   wire [`ADDR_W-1:0] wr_addr;
   wire [7:0] wr_data;
   wire head_done;
   wire frame_done;
   reg [7:0] rd_data;

   // Inputs are synchronous to ref_clk, so a delayed copy finds the edge
   assign sclk_rise = sclk & ~sclk_d_r & ~sen_n;

   // Word as it stands once the current bit is shifted in
   assign frame_word = {shift_r, sdi};
   assign head_addr = frame_word[`ADDR_W-1:0];
   assign wr_addr = frame_word[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB];
   assign wr_data = frame_word[`FRAME_DATA_MSB:0];
   assign head_done = sclk_rise && (bit_cnt_r == `FRAME_HEAD_BITS - 1);
   assign frame_done = sclk_rise && (bit_cnt_r == `FRAME_BITS - 1);

   // One register per frame; there is no address auto-increment
   // Read mux; unmapped addresses read as zero
   always @*
   begin
      case (head_addr)
         `ADDR_REVISION_CODE: rd_data = REVISION_VALUE; // [R8]
         `ADDR_PRODUCT_CODE: rd_data = PRODUCT_VALUE; // [R8]
         `ADDR_SOFT_RESET_CTRL: rd_data = soft_reset_r; // [R7]
         `ADDR_POWER_DOWN_CTRL: rd_data = power_down_r; // [R7]
         `ADDR_FIRST_CHANNEL_BIAS: rd_data = bias_r[0]; // [R7]
         `ADDR_FIRST_CHANNEL_GAIN: rd_data = gain_r[0]; // [R7]
         `ADDR_SECOND_CHANNEL_BIAS: rd_data = bias_r[1]; // [R7]
         `ADDR_SECOND_CHANNEL_GAIN: rd_data = gain_r[1]; // [R7]
         default: rd_data = 8'h00;
      endcase
   end

   // The data bit leaves only in the data phase of a read frame
   assign sdo_oe = frame_on_r & is_read_r & ~sen_n; // [R7]

   // Next state of the bit counter and frame flags
   reg [`BIT_CNT_W-1:0] bit_cnt_nxt;
   reg is_read_nxt;
   reg frame_on_nxt;

   always @*
   begin
      bit_cnt_nxt = bit_cnt_r;
      is_read_nxt = is_read_r;
      frame_on_nxt = frame_on_r;
      if (sen_n)
      begin
         // Deselect aborts a short frame so a half-written word never lands
         bit_cnt_nxt = {`BIT_CNT_W{1'b0}};
         is_read_nxt = 1'b0;
         frame_on_nxt = 1'b0;
      end
      else if (sclk_rise)
      begin
         if (bit_cnt_r == {`BIT_CNT_W{1'b0}})
         begin
            is_read_nxt = sdi; // [R7]
         end
         if (head_done)
         begin
            frame_on_nxt = 1'b1;
         end
         if (frame_done)
         begin
            // Further clocks in the same select are ignored
            frame_on_nxt = 1'b0;
            is_read_nxt = 1'b0;
         end
         // Counter parks at a full frame so extra clocks cannot wrap it
         if (bit_cnt_r != `FRAME_BITS)
         begin
            bit_cnt_nxt = bit_cnt_r + 1'b1;
         end
      end
   end

   // Bit counter and input shifter
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sclk_d_r <= 1'b0;
         bit_cnt_r <= {`BIT_CNT_W{1'b0}};
         shift_r <= {(`FRAME_BITS-1){1'b0}};
         is_read_r <= 1'b0;
         frame_on_r <= 1'b0;
      end
      else if (clk_en)
      begin
         sclk_d_r <= sclk;
         bit_cnt_r <= bit_cnt_nxt;
         is_read_r <= is_read_nxt;
         frame_on_r <= frame_on_nxt;
         if (sclk_rise)
         begin
            shift_r <= frame_word[`FRAME_BITS-2:0];
         end
      end
   end

   // Read data: first bit loads with the address, the rest follow each edge
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_shift_r <= 8'h00;
         sdo <= 1'b0;
      end
      else if (clk_en)
      begin
         if (head_done && is_read_r)
         begin
            sdo <= rd_data[7]; // [R7]
            rd_shift_r <= {rd_data[6:0], 1'b0};
         end
         else if (sclk_rise && frame_on_r)
         begin
            sdo <= rd_shift_r[7];
            rd_shift_r <= {rd_shift_r[6:0], 1'b0};
         end
         else if (sen_n)
         begin
            sdo <= 1'b0;
         end
      end
   end

   // Writes commit on the last bit of a complete write frame
   wire do_write;
   assign do_write = frame_done && !is_read_r && frame_on_r; // [R7]

   // Next values of the shared control registers
   reg [7:0] soft_reset_nxt;
   reg [7:0] power_down_nxt;

   always @*
   begin
      soft_reset_nxt = soft_reset_r;
      power_down_nxt = power_down_r;
      if (wr_hit(do_write, wr_addr, `ADDR_SOFT_RESET_CTRL))
      begin
         soft_reset_nxt = wr_data; // [R6]
      end
      if (wr_hit(do_write, wr_addr, `ADDR_POWER_DOWN_CTRL))
      begin
         power_down_nxt = wr_data; // [R6]
      end
      // Writes to the identity addresses fall through untouched [R8]
   end

   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         soft_reset_r <= `RST_SOFT_RESET_CTRL; // [R6]
         power_down_r <= `RST_POWER_DOWN_CTRL; // [R6]
         write_done <= 1'b0;
      end
      else if (clk_en)
      begin
         soft_reset_r <= soft_reset_nxt;
         power_down_r <= power_down_nxt;
         write_done <= do_write;
      end
   end

   // Per-channel bias and gain, each channel at its own pair of addresses
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1)
      begin : chan
         // Offsets worked out wide, then cut to the address width on purpose
         localparam integer BIAS_OFS = `ADDR_FIRST_CHANNEL_BIAS + 2 * ch;
         localparam integer GAIN_OFS = `ADDR_FIRST_CHANNEL_GAIN + 2 * ch;
         localparam [`ADDR_W-1:0] BIAS_ADDR = BIAS_OFS[`ADDR_W-1:0];
         localparam [`ADDR_W-1:0] GAIN_ADDR = GAIN_OFS[`ADDR_W-1:0];

         reg [7:0] bias_nxt;
         reg [7:0] gain_nxt;

         always @*
         begin
            bias_nxt = bias_r[ch];
            gain_nxt = gain_r[ch];
            if (wr_hit(do_write, wr_addr, BIAS_ADDR))
            begin
               bias_nxt = wr_data; // [R5]
            end
            if (wr_hit(do_write, wr_addr, GAIN_ADDR))
            begin
               gain_nxt = wr_data; // [R1] [R4]
            end
         end

         always @(posedge ref_clk or negedge resetn)
         begin
            if (!resetn)
            begin
               bias_r[ch] <= `RST_CHANNEL_BIAS; // [R5]
               gain_r[ch] <= `RST_CHANNEL_GAIN; // [R4]
               gain_db_r[ch] <= `RST_GAIN_DB; // [R4]
            end
            else if (clk_en)
            begin
               bias_r[ch] <= bias_nxt;
               gain_r[ch] <= gain_nxt;
               // Decibel view trails the code by one cycle
               gain_db_r[ch] <= code_to_db(gain_r[ch]); // [R1] [R2] [R3]
            end
         end
      end
   endgenerate

   // Configuration outputs straight from the register flops
   assign soft_reset_code = soft_reset_r;
   assign power_down_code = power_down_r;
   assign first_bias_code = bias_r[0];
   assign first_gain_code = gain_r[0];
   assign second_bias_code = bias_r[1];
   assign second_gain_code = gain_r[1];
   assign first_gain_db = gain_db_r[0];
   assign second_gain_db = gain_db_r[1];

endmodule // dual_gain_amp_register_bank

//--- test/dual_gain_amp_chk.sv
`timescale 1ns/1ps
module dual_gain_amp_chk
(
   // Clock and control
   input wire ref_clk,
   input wire resetn,
   input wire clk_en,
   input wire sen_n,
   // Observed outputs
   input wire sdo_oe,
   input wire write_done,
   input wire [7:0] soft_reset_code,
   input wire [7:0] power_down_code,
   input wire [7:0] first_bias_code,
   input wire [7:0] first_gain_code,
   input wire [7:0] second_bias_code,
   input wire [7:0] second_gain_code,
   input wire [7:0] first_gain_db,
   input wire [7:0] second_gain_db
);
   wire [39:0] rest_w = {soft_reset_code, power_down_code, first_bias_code, second_bias_code,
      second_gain_code};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence commit_s;
      clk_en && write_done;
   endsequence
   pulse_once_a: assert property (commit_s |=> !write_done)
      else $error("write_done too long");
   done_framed_a: assert property (write_done |-> !$past(sen_n))
      else $error("write_done outside a frame");
   oe_select_a: assert property (sen_n |-> !sdo_oe)
      else $error("sdo driven while deselected");
   first_db_a: assert property (clk_en && first_gain_code <= 8'h27 |=>
      first_gain_db == 8'h1E - $past(first_gain_code)) else $error("first dB wrong");
   first_floor_a: assert property (clk_en && first_gain_code > 8'h27 |=>
      first_gain_db == 8'hF7) else $error("first dB not at floor");
   second_db_a: assert property (clk_en |=> second_gain_db ==
      ($past(second_gain_code) > 8'h27 ? 8'hF7 : 8'h1E - $past(second_gain_code)))
      else $error("second dB wrong");
   first_hold_a: assert property ($changed(first_gain_code) |-> write_done)
      else $error("first gain changed without write");
   rest_hold_a: assert property ($changed(rest_w) |-> write_done)
      else $error("register changed without write");
   freeze_a: assert property (!clk_en |=> $stable(rest_w) && $stable(first_gain_code))
      else $error("state moved while disabled");
endmodule // dual_gain_amp_chk

bind dual_gain_amp_register_bank dual_gain_amp_chk chk_u (.*);

//--- test/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model
(
   // Clock and serial lines
   input wire ref_clk,
   input wire sdo,
   output reg sclk = 1'b0,
   output reg sen_n = 1'b1,
   output reg sdi = 1'b0,
   // Read results
   output reg [7:0] rd_data = 8'h00,
   output reg rd_stb = 1'b0
);
   // A frame cut short at nb bits models a host that aborts mid-frame
   task automatic frame(input rd, input [6:0] a, input [7:0] d, input integer nb);
      reg [15:0] w;
      integer i;
      begin
         w = {rd, a, d};
         @(posedge ref_clk) #1 sen_n = 1'b0;
         for (i = 0; i < nb; i++)
         begin
            repeat (4) @(posedge ref_clk);
            #1 sdi = w[15 - i];
            sclk = 1'b1;
            rd_data = {rd_data[6:0], sdo};
            repeat (4) @(posedge ref_clk);
            #1 sclk = 1'b0;
         end
         repeat (4) @(posedge ref_clk);
         #1 sen_n = 1'b1;
         // Idle data line must not echo the last bit
         sdi = ~sdi;
         if (rd && nb == 16)
            rd_stb = ~rd_stb;
      end
   endtask
endmodule // serial_host_model

//--- test/dual_gain_amp_register_bank_tb_top.sv
`timescale 1ns/1ps
`include "dual_gain_amp_regs.vh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h seen %h", nm, e, s); end end
module dual_gain_amp_register_bank_tb_top;
   localparam [7:0] REV = 8'h3C; // Arbitrary value
   localparam [7:0] PROD = 8'hC3; // Arbitrary value
   reg ref_clk = 1'b0;
   reg resetn = 1'b0;
   reg clk_en = 1'b1;
   wire sclk, sen_n, sdi, sdo, sdo_oe, write_done, rd_stb;
   wire [7:0] rd_data, db1, db2;
   wire [7:0] sr_code, pd_code, b1_code, g1_code, b2_code, g2_code;
   integer rises = 0;
   reg rd_frame = 1'b0;
   integer fail_count = 0;
   integer n_compared = 0;
   integer i, c;
   reg [15:0] exp_q[$];
   reg [15:0] e;
   reg [7:0] mem [0:7];
   dual_gain_amp_register_bank #(.REVISION_VALUE(REV), .PRODUCT_VALUE(PROD), .CHANNELS(2)) dut_u
      (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .sclk(sclk), .sen_n(sen_n),
      .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .soft_reset_code(sr_code),
      .power_down_code(pd_code), .first_bias_code(b1_code), .first_gain_code(g1_code),
      .second_bias_code(b2_code), .second_gain_code(g2_code),
      .first_gain_db(db1), .second_gain_db(db2), .write_done(write_done));
   // A released data line shows the inverse, so only driven bits can match
   serial_host_model host_u (.ref_clk(ref_clk), .sdo(sdo_oe ? sdo : ~sdo), .sclk(sclk),
      .sen_n(sen_n),
      .sdi(sdi), .rd_data(rd_data), .rd_stb(rd_stb));
   initial
      forever #50 ref_clk = ~ref_clk;
   task test_done;
      begin
         if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task do_reset;
      begin
         #1 resetn = 1'b0;
         repeat (2) @(posedge ref_clk);
         #1 resetn = 1'b1;
         mem[0] = REV;
         mem[1] = PROD;
         mem[2] = `RST_SOFT_RESET_CTRL;
         mem[3] = `RST_POWER_DOWN_CTRL;
         for (i = 4; i < 8; i++)
            mem[i] = i[0] ? `RST_CHANNEL_GAIN : `RST_CHANNEL_BIAS;
      end
   endtask
   task check_codes;
      begin
         `CHK("soft reset code", mem[2], sr_code)
         `CHK("power down code", mem[3], pd_code)
         `CHK("first bias code", mem[4], b1_code)
         `CHK("first gain code", mem[5], g1_code)
         `CHK("second bias code", mem[6], b2_code)
         `CHK("second gain code", mem[7], g2_code)
      end
   endtask
   // Read-only and unmapped places keep their model value, so writes there must not stick
   task wr(input [6:0] a, input [7:0] d);
      begin
         host_u.frame(1'b0, a, d, 16);
         if (a > 1 && a < 8 && clk_en)
            mem[a[2:0]] = d;
         check_codes;
      end
   endtask
   // The data line is driven only from the ninth clock of a read frame on
   always @(posedge sclk)
   begin
      if (rises == 0)
         rd_frame = sdi;
      `CHK("sdo_oe", rd_frame && rises >= 8, sdo_oe)
      rises++;
   end
   always @(posedge sen_n)
      rises = 0;
   task rd(input [6:0] a);
      begin
         exp_q.push_back({1'b0, a, a < 8 ? mem[a[2:0]] : 8'h00});
         host_u.frame(1'b1, a, 8'($urandom), 16);
      end
   endtask
   task gain(input [7:0] c1, input [7:0] c2);
      begin
         wr(`ADDR_FIRST_CHANNEL_GAIN, c1);
         wr(`ADDR_SECOND_CHANNEL_GAIN, c2);
         `CHK("first db", c1 > `GAIN_CODE_MAX ? 8'hF7 : 8'h1E - c1, db1)
         `CHK("second db", c2 > `GAIN_CODE_MAX ? 8'hF7 : 8'h1E - c2, db2)
      end
   endtask
   always @(rd_stb)
   begin
      e = exp_q.pop_front();
      `CHK($sformatf("reg %0h", e[14:8]), e[7:0], rd_data)
   end
   initial
   begin
      #5_000_000;
      fail_count++;
      test_done;
   end
   initial
   begin
      c = $urandom(32'h0003);
      do_reset;
      for (i = 0; i < 8; i++)
         rd(i[6:0]);
      rd(7'h7F);
      for (i = 0; i < 9; i++)
         wr(i[6:0], 8'($urandom));
      for (i = 0; i < 9; i++)
         rd(i[6:0]);
      gain(8'h00, 8'h27);
      gain(8'h27, 8'h28);
      gain(8'hFF, 8'h00);
      gain(8'($urandom % 40), 8'($urandom % 40));
      rd(`ADDR_FIRST_CHANNEL_GAIN);
      host_u.frame(1'b0, `ADDR_FIRST_CHANNEL_GAIN, 8'h01, 10);
      rd(`ADDR_FIRST_CHANNEL_GAIN);
      @(posedge ref_clk) #1 clk_en = 1'b0;
      wr(`ADDR_FIRST_CHANNEL_BIAS, 8'h3A);
      @(posedge ref_clk) #1 clk_en = 1'b1;
      rd(`ADDR_FIRST_CHANNEL_BIAS);
      wr(`ADDR_SECOND_CHANNEL_BIAS, 8'h11);
      do_reset;
      check_codes;
      rd(`ADDR_SECOND_CHANNEL_BIAS);
      rd(`ADDR_SECOND_CHANNEL_GAIN);
      #1000;
      `CHK("reads left", 0, exp_q.size())
      test_done;
   end
endmodule // dual_gain_amp_register_bank_tb_top
